// *** hdl/dcc_map.svh ***
// Notes on behaviour
// - Convert only on selected source trigger
// - Ready flag low during conversion
// - Ready flag set when conversion completes
// - External select ignores software and pacer
// - Three sources: software, pacer, external
// - A soft trigger write while idle starts conversion under software select; one while busy is dropped
// - Pacer from two cascaded counters
// - External rising edge starts conversion
// - External trigger works with every transfer
// - Transfer mode from control bits
// - Result word read clears ready
// - Host polls ready before reading result
// - Conversion ends within 8 us
// - Interrupt request when result ready
// - Bus master mode queues results in FIFO
// - DAC write updates its analog output
// - DAC code is 12 bits
// - Digital ports whole 16-bit words only
// - Status bit1 overrun, bit0 ready
// - Host programs legal modes; control bit map
// - Pacer select ignored under external trigger
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH
// Device I/O offsets
`define DCC_OFS_PACER_ONE 6'h04
`define DCC_OFS_PACER_TWO 6'h08
`define DCC_OFS_DAC_ONE 6'h10
`define DCC_OFS_DAC_TWO 6'h14
`define DCC_OFS_MODE 6'h18
`define DCC_OFS_DIO 6'h1c
`define DCC_OFS_SOFT_TRIG 6'h20
`define DCC_OFS_RESULT 6'h24
// Mode control and status bits
`define DCC_BIT_BUS_MASTER 0
`define DCC_BIT_IRQ_XFER 1
`define DCC_BIT_PACER_SEL 2
`define DCC_BIT_OUTSIDE_SEL 3
`define DCC_BIT_READY 0
`define DCC_BIT_OVERRUN 1
// Host register offsets on AHB-Lite
`define DCC_HOFS_IO_ADDR 5'h00
`define DCC_HOFS_IO_WDATA 5'h04
`define DCC_HOFS_IO_GO 5'h08
`define DCC_HOFS_STATUS 5'h0c
`define DCC_HOFS_IO_RDATA 5'h10
`define DCC_HOFS_DMA_DATA 5'h14
// Timing
`define DCC_MCLK_HZ 50000000
`define DCC_CLK_PERIOD_NS 20
`define DCC_CONV_MAX_NS 8000
`define DCC_CONV_CYCLES ((`DCC_CONV_MAX_NS) / (`DCC_CLK_PERIOD_NS))
`define DCC_PACER_BASE_HZ 2000000
`define DCC_PACER_DIV ((`DCC_MCLK_HZ) / (`DCC_PACER_BASE_HZ))
`define DCC_FIFO_DEPTH 8
`endif

// *** hdl/dcc_pkg.sv ***
package dcc_pkg;
	typedef enum logic [1:0] {
		DCC_CONV_IDLE = 2'b01,
		DCC_CONV_BUSY = 2'b10
	} dcc_conv_e;

	typedef enum logic [2:0] {
		DCC_HOST_IDLE = 3'b001,
		DCC_HOST_ISSUE = 3'b010,
		DCC_HOST_WAIT = 3'b100
	} dcc_host_e;

	typedef struct packed {
		dcc_conv_e st;
		logic [8:0] tmr;
		logic [4:0] pre;
		logic [15:0] c1;
		logic [15:0] c2;
		logic [15:0] p1;
		logic [15:0] p2;
		logic [3:0] ctrl;
		logic rdy;
		logic ovr;
		logic [11:0] result;
		logic [11:0] dac1;
		logic [11:0] dac2;
		logic [15:0] dout;
		logic [15:0] rdata;
		logic start;
		logic [2:0] wp;
		logic [2:0] rp;
		logic [3:0] cnt;
		logic [7:0][11:0] fifo;
		logic ext1;
		logic ext2;
		logic ext3;
		logic dn1;
		logic dn2;
		logic dn3;
		logic [15:0] di1;
		logic [15:0] di2;
		logic [11:0] rs1;
		logic [11:0] rs2;
	} dcc_dev_s;

	typedef struct packed {
		dcc_host_e st;
		logic [5:0] io_addr;
		logic [15:0] io_wdata;
		logic io_wr;
		logic io_rd;
		logic want_wr;
		logic [15:0] rd_result;
		logic [31:0] hrdata;
		logic dph_wr;
		logic [4:0] dph_addr;
	} dcc_host_s;
endpackage

// *** hdl/dcc_if.sv ***
`timescale 1ns/1ns
interface dcc_if;
	logic [5:0] io_addr;
	logic [15:0] io_wdata;
	logic io_wr;
	logic io_rd;
	logic [15:0] io_rdata;
	logic irq_req;
	logic dma_valid;
	logic [11:0] dma_data;
	logic dma_ready;

	modport card (
		input io_addr, io_wdata, io_wr, io_rd, dma_ready,
		output io_rdata, irq_req, dma_valid, dma_data
	);
	modport bridge (
		output io_addr, io_wdata, io_wr, io_rd, dma_ready,
		input io_rdata, irq_req, dma_valid, dma_data
	);
endinterface

// *** hdl/dcc_card.sv ***
`timescale 1ns/1ns
`include "dcc_map.svh"
module dcc_card
	import dcc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	dcc_if.card bus,
	input wire logic outside_trigger_input,
	input wire logic conv_done,
	input wire logic [11:0] conv_data,
	input wire logic [15:0] dig_in,
	output logic conv_start,
	output logic [15:0] dig_out,
	output logic [11:0] analog_out_one,
	output logic [11:0] analog_out_two
);
	dcc_dev_s r;
	dcc_dev_s next_r;

	// ============================================================
	// Derived events
	logic outside_rise;
	logic done_rise;
	logic pre_tick;
	logic pacer_fire;
	logic soft_fire;
	logic trig;
	logic finish;
	logic wr_soft;
	logic push;
	logic pop;
	logic trig_outside_select;
	logic internal_pacer_select;
	logic xfer_bus_master;
	logic xfer_irq;
	logic fifo_empty;
	logic fifo_full;

	assign trig_outside_select = r.ctrl[`DCC_BIT_OUTSIDE_SEL];
	assign internal_pacer_select = r.ctrl[`DCC_BIT_PACER_SEL];
	assign outside_rise = r.ext2 & ~r.ext3;
	assign done_rise = r.dn2 & ~r.dn3;
	assign pre_tick = (r.pre == 5'h00);
	assign pacer_fire = pre_tick && (r.c1 <= 16'h0001) && (r.c2 <= 16'h0001);
	assign wr_soft = bus.io_wr && (bus.io_addr == `DCC_OFS_SOFT_TRIG);
	assign soft_fire = wr_soft;

	// Source selection: external wins, pacer select only counts internally
	always_comb
	begin
		if (trig_outside_select)
			trig = outside_rise;
		else if (internal_pacer_select)
			trig = pacer_fire;
		else
			trig = soft_fire;
	end

	// Completion on converter done or at the 8 us bound, whichever first
	assign finish = (r.st == DCC_CONV_BUSY) && (done_rise || (r.tmr == 9'h000));
	assign push = finish && xfer_bus_master && !fifo_full;
	assign pop = bus.dma_ready && !fifo_empty;

	// ============================================================
	// Transfer mode and queue level
	// Bus master and interrupt may be on together; the queue and the
	// request then run side by side and the host must serve both
	assign xfer_bus_master = r.ctrl[`DCC_BIT_BUS_MASTER];
	assign xfer_irq = r.ctrl[`DCC_BIT_IRQ_XFER];
	assign fifo_empty = (r.cnt == 4'h0);
	assign fifo_full = (r.cnt == 4'(`DCC_FIFO_DEPTH));

	// ============================================================
	// Next state
	always_comb
	begin
		next_r = r;
		next_r.ext1 = outside_trigger_input;
		next_r.ext2 = r.ext1;
		next_r.ext3 = r.ext2;
		next_r.dn1 = conv_done;
		next_r.dn2 = r.dn1;
		next_r.dn3 = r.dn2;
		next_r.di1 = dig_in;
		next_r.di2 = r.di1;
		next_r.rs1 = conv_data;
		next_r.rs2 = r.rs1;
		next_r.start = 1'b0;

		// Pacer: prescaler to 2 MHz, then two cascaded down counters
		// A reload of 0 acts as 1, so with both reloads 0 the pacer fires on every tick
		next_r.pre = pre_tick ? 5'(`DCC_PACER_DIV - 1) : r.pre - 5'h01;
		if (pre_tick)
		begin
			if (r.c1 <= 16'h0001)
			begin
				next_r.c1 = r.p1;
				next_r.c2 = (r.c2 <= 16'h0001) ? r.p2 : r.c2 - 16'h0001;
			end
			else
				next_r.c1 = r.c1 - 16'h0001;
		end

		// Register writes
		if (bus.io_wr)
		begin
			case (bus.io_addr)
				`DCC_OFS_PACER_ONE:
				begin
					next_r.p1 = bus.io_wdata;
					next_r.c1 = bus.io_wdata;
				end
				`DCC_OFS_PACER_TWO:
				begin
					next_r.p2 = bus.io_wdata;
					next_r.c2 = bus.io_wdata;
				end
				`DCC_OFS_DAC_ONE: next_r.dac1 = bus.io_wdata[11:0];
				`DCC_OFS_DAC_TWO: next_r.dac2 = bus.io_wdata[11:0];
				`DCC_OFS_MODE:
				begin
					next_r.ctrl = bus.io_wdata[3:0];
					next_r.ovr = 1'b0;
				end
				`DCC_OFS_DIO: next_r.dout = bus.io_wdata;
				default: next_r.ctrl = next_r.ctrl;
			endcase
		end

		// Register reads: answer one cycle later from a flop
		next_r.rdata = 16'h0000;
		if (bus.io_rd)
		begin
			case (bus.io_addr)
				`DCC_OFS_MODE: next_r.rdata = {14'h0000, r.ovr, r.rdy};
				`DCC_OFS_DIO: next_r.rdata = r.di2;
				`DCC_OFS_RESULT: next_r.rdata = {4'h0, r.result};
				default: next_r.rdata = 16'h0000;
			endcase
			if (bus.io_addr == `DCC_OFS_RESULT)
				next_r.rdy = 1'b0;
		end

		// Conversion sequence; triggers while busy are dropped
		case (r.st)
			DCC_CONV_IDLE:
			begin
				if (trig)
				begin
					next_r.st = DCC_CONV_BUSY;
					next_r.start = 1'b1;
					next_r.rdy = 1'b0;
					next_r.tmr = 9'(`DCC_CONV_CYCLES - 1);
				end
			end
			DCC_CONV_BUSY:
			begin
				next_r.rdy = 1'b0;
				next_r.tmr = r.tmr - 9'h001;
				if (finish)
				begin
					next_r.st = DCC_CONV_IDLE;
					next_r.result = r.rs2;
					// Placed after the read clear so a fresh sample is never lost unseen
					next_r.rdy = 1'b1;
					// Full queue: the new sample is dropped, the older ones kept
					if (xfer_bus_master && !push)
						next_r.ovr = 1'b1;
				end
			end
			default: next_r.st = DCC_CONV_IDLE;
		endcase

		// Local FIFO for bus master transfer
		if (push)
		begin
			next_r.fifo[r.wp] = r.rs2;
			next_r.wp = r.wp + 3'h1;
		end
		if (pop)
			next_r.rp = r.rp + 3'h1;
		next_r.cnt = r.cnt + {3'h0, push} - {3'h0, pop};
	end

	// ============================================================
	// State register
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			r <= '0;
			r.st <= DCC_CONV_IDLE;
			// Prescaler starts loaded, so the first tick is a full period away
			r.pre <= 5'(`DCC_PACER_DIV - 1);
		end
		else
			r <= next_r;
	end

	// ============================================================
	// Outputs
	assign conv_start = r.start;
	assign dig_out = r.dout;
	assign analog_out_one = r.dac1;
	assign analog_out_two = r.dac2;
	assign bus.io_rdata = r.rdata;
	assign bus.irq_req = xfer_irq & r.rdy;
	assign bus.dma_valid = !fifo_empty;
	assign bus.dma_data = r.fifo[r.rp];
endmodule

// *** hdl/dcc_bridge.sv ***
`timescale 1ns/1ns
`include "dcc_map.svh"
module dcc_bridge
	import dcc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	dcc_if.bridge bus,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq
);
	dcc_host_s r;
	dcc_host_s next_r;
	logic aph;
	logic dma_take;
	logic busy;

	// ============================================================
	// AHB-Lite slave, zero wait states
	assign aph = hsel && htrans[1] && hready && (hsize == 3'b010);
	assign dma_take = aph && !hwrite && (haddr[4:0] == `DCC_HOFS_DMA_DATA) && bus.dma_valid;
	assign busy = (r.st != DCC_HOST_IDLE);

	always_comb
	begin
		next_r = r;
		next_r.io_wr = 1'b0;
		next_r.io_rd = 1'b0;
		next_r.dph_wr = aph && hwrite;
		next_r.dph_addr = haddr[4:0];

		if (aph && !hwrite)
		begin
			case (haddr[4:0])
				`DCC_HOFS_IO_ADDR: next_r.hrdata = {26'h0000000, r.io_addr};
				`DCC_HOFS_IO_WDATA: next_r.hrdata = {16'h0000, r.io_wdata};
				`DCC_HOFS_STATUS: next_r.hrdata = {29'h00000000, bus.dma_valid, bus.irq_req, busy};
				`DCC_HOFS_IO_RDATA: next_r.hrdata = {16'h0000, r.rd_result};
				`DCC_HOFS_DMA_DATA: next_r.hrdata = bus.dma_valid ? {20'h00000, bus.dma_data} : 32'h00000000;
				default: next_r.hrdata = 32'h00000000;
			endcase
		end

		if (r.dph_wr)
		begin
			case (r.dph_addr)
				`DCC_HOFS_IO_ADDR: next_r.io_addr = hwdata[5:0];
				`DCC_HOFS_IO_WDATA: next_r.io_wdata = hwdata[15:0];
				default: next_r.io_addr = next_r.io_addr;
			endcase
		end

		// Device access sequencer; a start while busy is dropped
		case (r.st)
			DCC_HOST_IDLE:
			begin
				if (r.dph_wr && (r.dph_addr == `DCC_HOFS_IO_GO))
				begin
					next_r.st = DCC_HOST_ISSUE;
					next_r.want_wr = hwdata[0];
					next_r.io_wr = hwdata[0];
					next_r.io_rd = ~hwdata[0];
				end
			end
			DCC_HOST_ISSUE: next_r.st = r.want_wr ? DCC_HOST_IDLE : DCC_HOST_WAIT;
			DCC_HOST_WAIT:
			begin
				next_r.rd_result = bus.io_rdata;
				next_r.st = DCC_HOST_IDLE;
			end
			default: next_r.st = DCC_HOST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			r <= '0;
			r.st <= DCC_HOST_IDLE;
		end
		else
			r <= next_r;
	end

	// ============================================================
	// Outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r.hrdata;
	assign irq = bus.irq_req;
	assign bus.io_addr = r.io_addr;
	assign bus.io_wdata = r.io_wdata;
	assign bus.io_wr = r.io_wr;
	assign bus.io_rd = r.io_rd;
	assign bus.dma_ready = dma_take;
endmodule

// *** test/dcc_monitor.sv ***
`timescale 1ns/1ns
module dcc_monitor (
	input logic mclk,
	input logic reset_n,
	input logic [5:0] io_addr,
	input logic [15:0] io_wdata,
	input logic io_wr,
	input logic io_rd,
	input logic [15:0] io_rdata,
	input logic irq_req,
	input logic dma_valid,
	input logic [11:0] dma_data,
	input logic dma_ready
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ====
	// Link checks
	a_rdata_quiet: assert property (!io_rd |=> io_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	a_status_upper: assert property (io_rd && io_addr == 6'h18 |=> io_rdata[15:2] == 14'h0000)
		else $error("status upper bits not zero");
	a_status_ready: assert property (io_rd && io_addr == 6'h18 && irq_req |=> io_rdata[0])
		else $error("status ready low while interrupt pending");
	a_read_clears: assert property (io_rd && io_addr == 6'h24 |=> !irq_req)
		else $error("result read left ready set");
	a_irq_mask: assert property (io_wr && io_addr == 6'h18 && !io_wdata[1] |=> !irq_req)
		else $error("interrupt request while interrupt transfer off");
	a_dma_hold: assert property (dma_valid && !dma_ready |=> dma_valid && $stable(dma_data))
		else $error("queued word lost without pop");
	a_pop_valid: assert property (dma_ready |-> dma_valid)
		else $error("pop from empty queue");
	a_io_pulse: assert property (io_wr || io_rd |-> !(io_wr && io_rd) ##1 !io_wr && !io_rd)
		else $error("device access not a single pulse");
	c_result_read: cover property (io_rd && io_addr == 6'h24);
	c_dma_pop: cover property (dma_valid && dma_ready);
	c_irq: cover property (irq_req);
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ns
module tb;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic outside_trigger_input = 1'b0;
	logic conv_done = 1'b0;
	logic [11:0] conv_data = 12'h000;
	logic [15:0] dig_in = 16'h0000;
	logic hreadyout, hresp, irq, conv_start;
	logic [15:0] dig_out;
	logic [11:0] analog_out_one, analog_out_two;
	logic [31:0] hrdata, d;
	logic conv_en = 1'b1;
	int n_errors = 0;
	int check_count = 0;
	int n_start = 0;
	int n0 = 0;
	dcc_if dcc_if_i();
	dcc_card dcc_card_i(.mclk(mclk), .reset_n(reset_n), .bus(dcc_if_i.card),
		.outside_trigger_input(outside_trigger_input), .conv_done(conv_done), .conv_data(conv_data),
		.dig_in(dig_in), .conv_start(conv_start), .dig_out(dig_out), .analog_out_one(analog_out_one),
		.analog_out_two(analog_out_two));
	dcc_bridge dcc_bridge_i(.mclk(mclk), .reset_n(reset_n), .bus(dcc_if_i.bridge), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
	dcc_monitor dcc_monitor_i(.mclk(mclk), .reset_n(reset_n), .io_addr(dcc_if_i.io_addr),
		.io_wdata(dcc_if_i.io_wdata), .io_wr(dcc_if_i.io_wr), .io_rd(dcc_if_i.io_rd),
		.io_rdata(dcc_if_i.io_rdata), .irq_req(dcc_if_i.irq_req), .dma_valid(dcc_if_i.dma_valid),
		.dma_data(dcc_if_i.dma_data), .dma_ready(dcc_if_i.dma_ready));
	always #10 mclk = ~mclk;
	// ====
	// Converter: slow enough that a status read lands mid-conversion
	always @(posedge mclk)
	begin
		if (conv_start === 1'b1)
		begin
			n_start++;
			if (conv_en)
			begin
				repeat (60) @(posedge mclk);
				conv_done <= 1'b1;
				repeat (4) @(posedge mclk);
				conv_done <= 1'b0;
			end
		end
	end
	// ====
	// Bus tasks
	task ahb(input logic [4:0] a, input logic w, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {27'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask
	task busy;
		do ahb(5'h0c, 1'b0, 32'h0); while (d[0] !== 1'b0);
	endtask
	task dwr(input logic [5:0] o, input logic [15:0] v);
		ahb(5'h00, 1'b1, {26'h0, o});
		ahb(5'h04, 1'b1, {16'h0, v});
		ahb(5'h08, 1'b1, 32'h1);
		busy;
	endtask
	task drd(input logic [5:0] o);
		ahb(5'h00, 1'b1, {26'h0, o});
		ahb(5'h08, 1'b1, 32'h0);
		busy;
		ahb(5'h10, 1'b0, 32'h0);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ====
	// Tests
	initial
	begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		ahb(5'h0c, 1'b0, 32'h0);
		chk(d, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		ahb(5'h1c, 1'b0, 32'h0);
		chk(d, 32'h0);
		drd(6'h18);
		chk(d, 32'h0);
		$display("test reset done");
		dwr(6'h10, 16'hfabc);
		chk({20'h0, analog_out_one}, 32'habc);
		dwr(6'h14, 16'h0123);
		chk({20'h0, analog_out_two}, 32'h123);
		dwr(6'h1c, 16'ha55a);
		dig_in <= 16'h3cc3;
		drd(6'h1c);
		chk(d, 32'h3cc3);
		chk({16'h0, dig_out}, 32'ha55a);
		$display("test ports done");
		conv_data <= 12'h321;
		dwr(6'h20, 16'h00a7);
		drd(6'h18);
		chk(d, 32'h0);
		do drd(6'h18); while (d[0] !== 1'b1);
		chk(n_start, 1);
		drd(6'h24);
		chk(d, 32'h321);
		drd(6'h18);
		chk(d, 32'h0);
		drd(6'h24);
		chk(d, 32'h321);
		$display("test soft trigger done");
		conv_en <= 1'b0;
		dwr(6'h20, 16'h00ff);
		repeat (400) @(posedge mclk);
		drd(6'h18);
		chk(d, 32'h1);
		drd(6'h24);
		conv_en <= 1'b1;
		$display("test time bound done");
		dwr(6'h18, 16'h000e);
		dwr(6'h20, 16'h0000);
		repeat (100) @(posedge mclk);
		chk(n_start, 2);
		conv_data <= 12'h7e5;
		outside_trigger_input <= 1'b1;
		repeat (100) @(posedge mclk);
		chk({31'h0, irq}, 32'h1);
		chk(n_start, 3);
		drd(6'h18);
		chk(d, 32'h1);
		drd(6'h24);
		chk(d, 32'h7e5);
		chk({31'h0, irq}, 32'h0);
		outside_trigger_input <= 1'b0;
		$display("test external done");
		dwr(6'h04, 16'h0002);
		dwr(6'h08, 16'h0002);
		conv_data <= 12'h4b1;
		dwr(6'h18, 16'h0005);
		n0 = n_start;
		repeat (1500) @(posedge mclk);
		chk(n_start - n0, 15);
		drd(6'h18);
		chk({31'h0, d[1]}, 32'h1);
		// Second write clears an overrun set by a sample finishing beside the first
		dwr(6'h18, 16'h0000);
		dwr(6'h18, 16'h0000);
		for (int i = 0; i < 8; i++)
		begin
			ahb(5'h14, 1'b0, 32'h0);
			chk(d, 32'h4b1);
		end
		ahb(5'h0c, 1'b0, 32'h0);
		chk({31'h0, d[2]}, 32'h0);
		ahb(5'h14, 1'b0, 32'h0);
		chk(d, 32'h0);
		drd(6'h18);
		chk({31'h0, d[1]}, 32'h0);
		$display("test pacer dma done");
		close_out;
	end
	// Generous span: the tests need well under a third of it
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		close_out;
	end
endmodule
